//--- shared/msa_pkg.sv
// Contract
// - address types decode by range: private, generated, unassociated, multicast, broadcast.
// - exactly one own short address, private or generated type only.
// - a null extended identifier forces a private short address.
// - generated address drawn uniformly from generated range, unique in beacon group.
// - every transmitted frame carries own address in its source field.
// - unicast frames carry the recipient's short address as destination.
// - group frames carry a destination from the multicast range.
// - broadcast frames carry the all-ones destination.
// - never send to a private-address recipient outside a private reservation.
// - a private-address device sends only beacons outside private reservations.
// - unassociated devices are addressed with the reserved unassociated value.
// - generated holder flags conflict on a received header carrying its own source.
// - generated holder flags conflict on occupancy entry for a slot it missed awake.
// - a flagged conflict makes the device draw and adopt a new address.
// - frame received needs header ok flag, good check sequence, supported version.
// - header received needs header ok flag and supported version, check ignored.
package msa_pkg;
	// address ranges
	localparam logic [15:0] PRIV_MAX = 16'h00FF;
	localparam logic [15:0] GEN_MIN = 16'h0100;
	localparam logic [15:0] GEN_MAX = 16'hFEFF;
	localparam logic [15:0] UNASSOC = 16'hFF00;
	localparam logic [15:0] MCAST_MIN = 16'hFF01;
	localparam logic [15:0] MCAST_MAX = 16'hFFFE;
	localparam logic [15:0] BCAST = 16'hFFFF;
	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PRIV = 8'h04;
	localparam logic [7:0] REG_ADDR = 8'h08;
	localparam logic [7:0] REG_GROUP = 8'h0C;
	localparam logic [7:0] REG_IRQ_STS = 8'h10;
	localparam logic [7:0] REG_IRQ_CLR = 8'h14;
	localparam logic [7:0] REG_IRQ_EN = 8'h18;
	// control fields, then address register flag bits
	localparam int CTRL_NULL_EUI = 0;
	localparam int CTRL_FORCE_PRIV = 1;
	localparam int CTRL_REGEN = 2;
	localparam int CTRL_GROUP_EN = 3;
	localparam int ADDR_GEN_BIT = 16;
	localparam int ADDR_READY_BIT = 17;
	// interrupt status bits
	localparam int IRQ_CONFLICT = 0;
	localparam int IRQ_FRAME = 1;
	localparam int IRQ_HEADER = 2;
	localparam int IRQ_TX_DENY = 3;
	localparam int IRQ_DISCARD = 4;
	localparam int IRQ_W = 5;
	// lfsr reset value and taps, version field width
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
	localparam int VER_W = 3;
	// kinds of transmitted destination
	typedef enum logic [1:0] {
		MSA_UNICAST = 2'h0,
		MSA_MULTICAST = 2'h1,
		MSA_BROADCAST = 2'h2,
		MSA_UNASSOC = 2'h3
	} msa_kind_t;
	typedef enum logic [2:0] {
		MSA_INIT = 3'h1,
		MSA_DRAW = 3'h2,
		MSA_HOLD = 3'h4
	} msa_state_t;
endpackage : msa_pkg

//--- shared/msa_rng_if.sv
`timescale 1ns/10ps
// random source carrier between the address keeper and its generator
interface msa_rng_if;
	logic step;
	logic [15:0] value;
	modport keeper (output step, input value);
	modport source (input step, output value);
endinterface : msa_rng_if

//--- rtl/msa_rng.sv
`timescale 1ns/10ps
// galois lfsr; visits every nonzero 16-bit value once per period
module msa_rng #(
	parameter logic [15:0] SEED = msa_pkg::LFSR_SEED
) (
	input wire logic ref_clk, // 25 MHz clock
	input wire logic rst_b, // async reset, active low
	msa_rng_if.source rng // step request and current value
);
	typedef struct packed {
		logic [15:0] lfsr;
	} msa_rng_st_t;
	msa_rng_st_t s;
	msa_rng_st_t next_s;

	////////////////////////////////////////////////////////////////
	// free running so the draw time adds entropy, step adds a turn
	always_comb
	begin
		next_s = s;
		next_s.lfsr = s.lfsr[0] ? ((s.lfsr >> 1) ^ msa_pkg::LFSR_TAPS) : (s.lfsr >> 1);
		if (rng.step)
		begin
			next_s.lfsr = next_s.lfsr[0] ?
				((next_s.lfsr >> 1) ^ msa_pkg::LFSR_TAPS) : (next_s.lfsr >> 1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			s <= '{lfsr: SEED};
		else
			s <= next_s;
	end

	assign rng.value = s.lfsr;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	lfsr_nonzero_a: assert property (s.lfsr != 16'h0000)
		else $error("lfsr stuck at zero");
endmodule : msa_rng

//--- rtl/msa_addr_keeper.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module msa_addr_keeper #(
	parameter logic [msa_pkg::VER_W-1:0] SUPPORTED_VER = '0,
	parameter logic [15:0] SEED = msa_pkg::LFSR_SEED
) (
	input wire logic ref_clk, // 25 MHz clock
	input wire logic rst_b, // async reset, active low
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	output logic irq, // level interrupt
	input wire logic tx_req, // transmit request pulse
	input wire logic [1:0] tx_kind, // destination kind
	input wire logic [15:0] tx_dest, // recipient or group address
	input wire logic tx_beacon, // frame is a beacon
	input wire logic tx_in_priv_resv, // inside a private reservation
	output logic tx_go, // frame may go, pulse
	output logic tx_deny, // frame refused, pulse
	output logic [15:0] source_address_field, // held source field
	output logic [15:0] destination_address_field, // held destination field
	input wire logic rx_strobe, // received header and check result
	input wire logic header_ok_flag, // PHY header indication
	input wire logic rx_fcs_ok, // check sequence passed
	input wire logic [msa_pkg::VER_W-1:0] rx_ver, // protocol version
	input wire logic [15:0] rx_src, // received source field
	input wire logic [15:0] rx_dst, // received destination field
	input wire logic bso_strobe, // one occupancy entry of a beacon
	input wire logic [15:0] bso_addr, // address listed in the entry
	input wire logic bso_we_sent, // we sent a beacon in that slot
	input wire logic hibernating, // we slept through that slot
	output logic rx_frame_ok, // frame received, pulse
	output logic rx_header_ok, // header received, pulse
	output logic rx_deliver, // frame for us, pulse
	output logic addr_conflict, // conflict seen, pulse
	output logic [15:0] device_short_address, // own address
	output logic addr_ready // own address valid
);
	typedef struct packed {
		msa_pkg::msa_state_t state;
		logic [15:0] addr;
		logic gen;
		logic null_eui;
		logic force_priv;
		logic group_en;
		logic [7:0] priv;
		logic [15:0] group_address;
		logic [msa_pkg::IRQ_W-1:0] sts;
		logic [msa_pkg::IRQ_W-1:0] en;
		logic [31:0] rdata;
		logic irq;
		logic tx_go;
		logic tx_deny;
		logic [15:0] src_f;
		logic [15:0] dst_f;
		logic frame_ok;
		logic hdr_ok;
		logic deliver;
		logic conflict;
	} msa_st_t;

	msa_st_t s;
	msa_st_t next_s;
	msa_rng_if rng_bus();

	msa_rng #(
		.SEED(SEED)
	) u_rng (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.rng(rng_bus.source)
	);

	// address type decode
	function automatic logic is_priv(input logic [15:0] a);
		is_priv = (a <= msa_pkg::PRIV_MAX);
	endfunction : is_priv

	function automatic logic is_mcast(input logic [15:0] a);
		is_mcast = (a >= msa_pkg::MCAST_MIN) && (a <= msa_pkg::MCAST_MAX);
	endfunction : is_mcast

	logic hold;
	logic hdr_good;
	logic self_src;
	logic bso_hit;
	logic dst_bad;
	logic [15:0] dst_val;
	logic [msa_pkg::IRQ_W-1:0] ev;
	logic [msa_pkg::IRQ_W-1:0] clr;

	////////////////////////////////////////////////////////////////
	// event decode, all same-clock inputs so no synchronisers
	always_comb
	begin
		hold = (s.state == msa_pkg::MSA_HOLD);
		hdr_good = header_ok_flag && (rx_ver == SUPPORTED_VER);
		self_src = rx_strobe && hdr_good && hold && s.gen && (rx_src == s.addr);
		bso_hit = bso_strobe && hold && s.gen && (bso_addr == s.addr)
			&& !bso_we_sent && !hibernating;
		dst_val = tx_dest;
		dst_bad = 1'b0;
		unique case (msa_pkg::msa_kind_t'(tx_kind))
			msa_pkg::MSA_UNICAST:
			begin
				dst_val = tx_dest;
				dst_bad = is_mcast(tx_dest) || (tx_dest >= msa_pkg::UNASSOC)
					|| (is_priv(tx_dest) && !tx_in_priv_resv);
			end
			msa_pkg::MSA_MULTICAST:
			begin
				dst_val = is_mcast(tx_dest) ? tx_dest : s.group_address;
				dst_bad = !is_mcast(dst_val);
			end
			msa_pkg::MSA_BROADCAST:
				dst_val = msa_pkg::BCAST;
			msa_pkg::MSA_UNASSOC:
				dst_val = msa_pkg::UNASSOC;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		next_s = s;
		rng_bus.step = 1'b0;
		next_s.tx_go = 1'b0;
		next_s.tx_deny = 1'b0;
		next_s.frame_ok = 1'b0;
		next_s.hdr_ok = 1'b0;
		next_s.deliver = 1'b0;
		next_s.conflict = self_src || bso_hit;
		ev = '0;
		clr = '0;

		// address selection
		unique case (s.state)
			msa_pkg::MSA_INIT:
			begin
				if (s.null_eui || s.force_priv)
				begin
					next_s.addr = {8'h00, s.priv};
					next_s.gen = 1'b0;
					next_s.state = msa_pkg::MSA_HOLD;
				end
				else
					next_s.state = msa_pkg::MSA_DRAW;
			end
			msa_pkg::MSA_DRAW:
			begin
				// rejection keeps the draw uniform; old value skipped after conflict
				rng_bus.step = 1'b1;
				if (rng_bus.value >= msa_pkg::GEN_MIN && rng_bus.value <= msa_pkg::GEN_MAX
					&& rng_bus.value != s.addr)
				begin
					next_s.addr = rng_bus.value;
					next_s.gen = 1'b1;
					next_s.state = msa_pkg::MSA_HOLD;
				end
			end
			msa_pkg::MSA_HOLD:
			begin
				if (self_src || bso_hit)
					next_s.state = msa_pkg::MSA_DRAW;
			end
			default:
				next_s.state = msa_pkg::MSA_INIT;
		endcase

		// transmit path: fields held until the next request
		if (tx_req)
		begin
			next_s.src_f = s.addr;
			next_s.dst_f = dst_val;
			if (!hold || dst_bad
				|| (is_priv(s.addr) && !tx_beacon && !tx_in_priv_resv))
			begin
				next_s.tx_deny = 1'b1;
				ev[msa_pkg::IRQ_TX_DENY] = 1'b1;
			end
			else
				next_s.tx_go = 1'b1;
		end

		// receive path
		if (rx_strobe)
		begin
			next_s.hdr_ok = hdr_good;
			next_s.frame_ok = hdr_good && rx_fcs_ok;
			next_s.deliver = hdr_good && rx_fcs_ok && hold && ((rx_dst == s.addr)
				|| (s.group_en && rx_dst == s.group_address)
				|| (rx_dst == msa_pkg::BCAST));
			ev[msa_pkg::IRQ_HEADER] = hdr_good;
			ev[msa_pkg::IRQ_FRAME] = hdr_good && rx_fcs_ok;
			ev[msa_pkg::IRQ_DISCARD] = hdr_good && rx_fcs_ok && !next_s.deliver;
		end
		ev[msa_pkg::IRQ_CONFLICT] = self_src || bso_hit;

		// register writes
		if (reg_wr)
		begin
			unique case (reg_addr)
				msa_pkg::REG_CTRL:
				begin
					next_s.null_eui = reg_wdata[msa_pkg::CTRL_NULL_EUI];
					next_s.force_priv = reg_wdata[msa_pkg::CTRL_FORCE_PRIV];
					next_s.group_en = reg_wdata[msa_pkg::CTRL_GROUP_EN];
					if (reg_wdata[msa_pkg::CTRL_REGEN])
						next_s.state = msa_pkg::MSA_INIT;
				end
				msa_pkg::REG_PRIV:
					next_s.priv = reg_wdata[7:0];
				msa_pkg::REG_GROUP:
					next_s.group_address = reg_wdata[15:0];
				msa_pkg::REG_IRQ_CLR:
					clr = reg_wdata[msa_pkg::IRQ_W-1:0];
				msa_pkg::REG_IRQ_EN:
					next_s.en = reg_wdata[msa_pkg::IRQ_W-1:0];
				default:
					clr = '0;
			endcase
		end
		// a new event wins over a clear in the same cycle
		next_s.sts = (s.sts & ~clr) | ev;
		next_s.irq = |(next_s.sts & next_s.en);

		// reads answer one cycle later; unmapped reads return zero
		next_s.rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			unique case (reg_addr)
				msa_pkg::REG_CTRL:
					next_s.rdata = {28'h0, s.group_en, 1'b0, s.force_priv, s.null_eui};
				msa_pkg::REG_PRIV:
					next_s.rdata = {24'h0, s.priv};
				msa_pkg::REG_ADDR:
					next_s.rdata = {14'h0, hold, s.gen, s.addr};
				msa_pkg::REG_GROUP:
					next_s.rdata = {16'h0, s.group_address};
				msa_pkg::REG_IRQ_STS:
					next_s.rdata = {27'h0, s.sts};
				msa_pkg::REG_IRQ_EN:
					next_s.rdata = {27'h0, s.en};
				default:
					next_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.state <= msa_pkg::MSA_INIT;
		end
		else
			s <= next_s;
	end

	// outputs straight from flops; addr_ready decoded from the state register
	assign reg_rdata = s.rdata;
	assign irq = s.irq;
	assign tx_go = s.tx_go;
	assign tx_deny = s.tx_deny;
	assign source_address_field = s.src_f;
	assign destination_address_field = s.dst_f;
	assign rx_frame_ok = s.frame_ok;
	assign rx_header_ok = s.hdr_ok;
	assign rx_deliver = s.deliver;
	assign addr_conflict = s.conflict;
	assign device_short_address = s.addr;
	assign addr_ready = (s.state == msa_pkg::MSA_HOLD);

	////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	addr_type_a: assert property (addr_ready |-> s.addr <= msa_pkg::GEN_MAX)
		else $error("own address not private or generated");
	null_eui_priv_a: assert property (addr_ready && !s.gen |-> s.addr[15:8] == 8'h00)
		else $error("private address out of range");
	gen_range_a: assert property (addr_ready && s.gen |-> s.addr >= msa_pkg::GEN_MIN)
		else $error("generated address below range");
	src_field_a: assert property (tx_req |=> (tx_go || tx_deny)
		&& source_address_field == $past(s.addr))
		else $error("source field not own address");
	bcast_dst_a: assert property (tx_go && $past(tx_kind) == 2'h2
		|-> destination_address_field == msa_pkg::BCAST)
		else $error("broadcast destination wrong");
	priv_dest_a: assert property (tx_go && $past(tx_kind) == 2'h0
		&& destination_address_field <= msa_pkg::PRIV_MAX |-> $past(tx_in_priv_resv))
		else $error("private recipient outside reservation");
	priv_own_a: assert property (tx_go && $past(s.addr) <= msa_pkg::PRIV_MAX
		&& !$past(tx_beacon) |-> $past(tx_in_priv_resv))
		else $error("private holder sent non-beacon outside reservation");
	self_src_a: assert property (self_src |=> addr_conflict
		##0 s.state == msa_pkg::MSA_DRAW || $past(reg_wr))
		else $error("own source not flagged as conflict");
	regen_a: assert property (addr_conflict && s.state == msa_pkg::MSA_DRAW
		|-> ##[1:300] addr_ready)
		else $error("no new address adopted");
	frame_ok_a: assert property (rx_strobe |=> rx_frame_ok == ($past(hdr_good)
		&& $past(rx_fcs_ok)) && rx_header_ok == $past(hdr_good))
		else $error("receive decision wrong");
	deliver_a: assert property (rx_deliver |-> rx_frame_ok)
		else $error("delivery without good frame");
	// destination per kind; nothing leaves while no address is bound
	uni_dst_a: assert property (tx_go && $past(tx_kind) == 2'h0
		|-> destination_address_field == $past(tx_dest)
		&& destination_address_field < msa_pkg::UNASSOC)
		else $error("unicast destination wrong");
	mcast_dst_a: assert property (tx_go && $past(tx_kind) == 2'h1
		|-> destination_address_field >= msa_pkg::MCAST_MIN
		&& destination_address_field <= msa_pkg::MCAST_MAX)
		else $error("group destination out of range");
	unassoc_dst_a: assert property (tx_go && $past(tx_kind) == 2'h3
		|-> destination_address_field == msa_pkg::UNASSOC)
		else $error("unassociated destination wrong");
	deny_unready_a: assert property (tx_req && !addr_ready |=> tx_deny && !tx_go)
		else $error("frame sent without a bound address");
	bso_hit_a: assert property (bso_strobe && addr_ready && s.gen
		&& bso_addr == device_short_address && !bso_we_sent && !hibernating
		|=> addr_conflict && !addr_ready)
		else $error("occupancy conflict missed");
	hdr_ok_a: assert property (rx_header_ok |-> $past(header_ok_flag)
		&& $past(rx_ver) == SUPPORTED_VER)
		else $error("header accepted without ok flag and version");
	priv_quiet_a: assert property (!s.gen |=> !addr_conflict)
		else $error("conflict flagged for a private address");

	// main scenarios
	ok_frame_c: cover property (rx_strobe ##1 rx_deliver);
	conflict_c: cover property (addr_conflict ##[1:50] addr_ready);
	tx_deny_c: cover property (tx_req ##1 tx_deny);
	bso_conflict_c: cover property (bso_strobe ##1 addr_conflict);
	unready_deny_c: cover property (tx_req && !addr_ready ##1 tx_deny);
endmodule : msa_addr_keeper

//--- testbench/msa_peer_model.sv
`timescale 1ns/10ps
// peer device and phy stand-in: presents one received header per request
module msa_peer_model (
	input wire logic ref_clk, // mac clock
	input wire logic rst_b, // async reset, active low
	input wire logic go, // present one header
	input wire logic phy_ok, // phy header decoded
	input wire logic mac_ok, // mac header decoded
	input wire logic [35:0] hdr, // {fcs ok, version, source, destination}
	output logic rx_strobe, // header pulse
	output logic header_ok_flag, // both headers decoded
	output logic [35:0] rx_bus // {fcs ok, version, source, destination}
);
	////////////////////////////////////////////////////////////////////////////////
	// idle fields flip every cycle so a stale header never looks valid
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_strobe <= 1'b0;
			header_ok_flag <= 1'b0;
			rx_bus <= '0;
		end
		else
		begin
			rx_strobe <= go;
			header_ok_flag <= go ? (phy_ok & mac_ok) : ~header_ok_flag;
			rx_bus <= go ? hdr : ~rx_bus;
		end
	end
endmodule : msa_peer_model

//--- testbench/test_mac_short_address_and_rx_accept.sv
`timescale 1ns/10ps
module test_mac_short_address_and_rx_accept;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, irq, tx_req = 1'b0, tx_beacon = 1'b0;
	logic tx_in_priv_resv = 1'b0, tx_go, tx_deny, go = 1'b0, phy_ok = 1'b0, mac_ok = 1'b0;
	logic [1:0] tx_kind = 2'h0;
	logic [15:0] tx_dest = 16'h0, source_address_field, destination_address_field;
	logic [15:0] device_short_address, bso_addr = 16'h0, own, nd;
	logic [35:0] hdr = 36'h0, rx_bus;
	logic bso_strobe = 1'b0, bso_we_sent = 1'b0, hibernating = 1'b0, rx_strobe, header_ok_flag;
	logic rx_frame_ok, rx_header_ok, rx_deliver, addr_conflict, addr_ready, hg, fo, dm;
	int error_cnt = 0, n_checks = 0, j, grp = 'hFF20;
	int dl[$] = '{0, 'h42, 'hFF05, 'h1234, 'hFFFF, 'hFF00};

	always #20 ref_clk = ~ref_clk;

	msa_addr_keeper u_dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.irq, .tx_req, .tx_kind, .tx_dest, .tx_beacon, .tx_in_priv_resv, .tx_go, .tx_deny,
		.source_address_field, .destination_address_field, .rx_strobe, .header_ok_flag,
		.rx_fcs_ok(rx_bus[35]), .rx_ver(rx_bus[34:32]), .rx_src(rx_bus[31:16]),
		.rx_dst(rx_bus[15:0]), .bso_strobe, .bso_addr, .bso_we_sent, .hibernating, .rx_frame_ok,
		.rx_header_ok, .rx_deliver, .addr_conflict, .device_short_address, .addr_ready);
	msa_peer_model u_peer (.ref_clk, .rst_b, .go, .phy_ok, .mac_ok, .hdr, .rx_strobe,
		.header_ok_flag, .rx_bus);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	// reference for transmit: -1 means refused, otherwise the destination field
	// own address o is -1 while none is bound
	function automatic int tx_model(int k, int d, int b, int r, int o);
		if (o < 0)
			return -1;
		if (o <= 'hFF && !b && !r)
			return -1;
		if (k == 0)
			return (d >= 'hFF00 || (d <= 'hFF && !r)) ? -1 : d;
		if (k == 1)
			return (d >= 'hFF01 && d <= 'hFFFE) ? d : (grp >= 'hFF01 && grp <= 'hFFFE) ? grp : -1;
		return (k == 2) ? 'hFFFF : 'hFF00;
	endfunction : tx_model

	// one strobe cycle; read data sampled just after the taking edge
	task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask : rw

	task automatic tx(input logic [1:0] k, input logic [15:0] d, input logic b, input logic r);
		int e;
		e = tx_model(k, d, b, r, addr_ready ? int'(device_short_address) : -1);
		@(posedge ref_clk);
		tx_req <= 1'b1;
		tx_kind <= k;
		tx_dest <= d;
		tx_beacon <= b;
		tx_in_priv_resv <= r;
		@(posedge ref_clk);
		tx_req <= 1'b0;
		#1;
		chk("tx_go", e >= 0, tx_go);
		chk("tx_deny", e < 0, tx_deny);
		if (e >= 0)
		begin
			chk("dst field", e, destination_address_field);
			chk("src field", device_short_address, source_address_field);
		end
	endtask : tx

	// header goes through the peer model, so the answer lands two edges later
	task automatic rx(input logic p, input logic m, input logic [35:0] h);
		@(posedge ref_clk);
		go <= 1'b1;
		phy_ok <= p;
		mac_ok <= m;
		hdr <= h;
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : rx

	task automatic bso(input logic w, input logic h);
		@(posedge ref_clk);
		bso_strobe <= 1'b1;
		bso_addr <= device_short_address;
		bso_we_sent <= w;
		hibernating <= h;
		@(posedge ref_clk);
		bso_strobe <= 1'b0;
		bso_addr <= ~device_short_address;
		#1;
		chk("bso conflict", !w && !h, addr_conflict);
	endtask : bso

	// bounded wait for a settled own address, then range and register view
	task automatic wait_rdy(input logic gen);
		for (int k = 0; k < 300 && addr_ready !== 1'b1; k++)
			@(posedge ref_clk);
		#1;
		chk("addr_ready", 1, addr_ready);
		rw(1'b0, msa_pkg::REG_ADDR, 32'h0);
		chk("addr reg", {14'h0, 1'b1, gen, device_short_address}, reg_rdata);
		if (gen)
			chk("gen range", 1, device_short_address >= msa_pkg::GEN_MIN
				&& device_short_address <= msa_pkg::GEN_MAX);
	endtask : wait_rdy

	////////////////////////////////////////////////////////////////////////////////
	// a hang counts as a mismatch and ends through the normal verdict
	initial
	begin
		#(40 * 8000);
		error_cnt++;
		test_done();
	end

	initial
	begin
		void'($urandom(32'h050F));
		repeat (3) @(posedge ref_clk);
		chk("ready in reset", 0, addr_ready);
		rst_b <= 1'b1;
		wait_rdy(1'b1);
		rw(1'b1, msa_pkg::REG_IRQ_EN, 32'h1);
		rw(1'b1, msa_pkg::REG_GROUP, grp);
		rw(1'b1, msa_pkg::REG_CTRL, 32'h8);
		rw(1'b0, 8'h40, 32'h0);
		chk("unmapped", 0, reg_rdata);
		rw(1'b0, msa_pkg::REG_IRQ_EN, 32'h0);
		chk("irq enable", 1, reg_rdata);
		dl[0] = $urandom;
		for (j = 0; j < 24; j++)
			tx(j % 4, dl[j % 6], 1'b0, $urandom);
		own = device_short_address;
		for (j = 0; j < 40; j++)
		begin
			hdr = {$urandom, $urandom};
			hdr[34:33] = 2'b00;
			hdr[15:0] = (j % 4 == 0) ? own : (j % 4 == 1) ? 16'hFFFF : (j % 4 == 2) ? 16'hFF20 : hdr[15:0];
			if (hdr[31:16] == own)
				hdr[31:16] = ~own;
			{phy_ok, mac_ok} = $urandom;
			hg = phy_ok & mac_ok & (hdr[34:32] == 3'h0);
			fo = hg & hdr[35];
			dm = (hdr[15:0] == own) || (hdr[15:0] == grp[15:0]) || (hdr[15:0] == 16'hFFFF);
			rx(phy_ok, mac_ok, hdr);
			chk("header ok", hg, rx_header_ok);
			chk("frame ok", fo, rx_frame_ok);
			chk("deliver", fo & dm, rx_deliver);
			chk("no conflict", 0, addr_conflict);
		end
		rw(1'b1, msa_pkg::REG_IRQ_EN, 32'h0);
		bso(1'b1, 1'b0);
		bso(1'b0, 1'b1);
		bso(1'b0, 1'b0);
		chk("ready drop", 0, addr_ready);
		wait_rdy(1'b1);
		chk("new addr", 1, device_short_address !== own);
		chk("irq masked", 0, irq);
		rw(1'b0, msa_pkg::REG_IRQ_STS, 32'h0);
		chk("irq status", 1, reg_rdata[0]);
		rw(1'b1, msa_pkg::REG_IRQ_EN, 32'h1);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("irq raised", 1, irq);
		rw(1'b1, msa_pkg::REG_IRQ_CLR, 32'h1);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("irq cleared", 0, irq);
		own = device_short_address;
		rx(1'b1, 1'b1, {1'b0, 3'h0, own, 16'h1234});
		chk("hdr conflict", 1, addr_conflict);
		wait_rdy(1'b1);
		chk("new addr", 1, device_short_address !== own);
		nd = {8'h00, 8'($urandom)};
		rw(1'b1, msa_pkg::REG_PRIV, {16'h0, nd});
		rw(1'b1, msa_pkg::REG_CTRL, 32'hD);
		repeat (2) @(posedge ref_clk);
		wait_rdy(1'b0);
		chk("private addr", nd, device_short_address);
		tx(2'h2, 16'h0, 1'b0, 1'b0);
		tx(2'h2, 16'h0, 1'b1, 1'b0);
		tx(2'h0, 16'h0203, 1'b0, 1'b1);
		rx(1'b1, 1'b1, {1'b1, 3'h0, nd, 16'hFFFF});
		chk("private no conflict", 0, addr_conflict);
		// group register out of range: group frames without an explicit target are refused
		grp = 'h0100;
		rw(1'b1, msa_pkg::REG_GROUP, grp);
		tx(2'h1, 16'h1234, 1'b1, 1'b0);
		tx(2'h1, 16'hFF07, 1'b1, 1'b0);
		rw(1'b1, msa_pkg::REG_CTRL, 32'h6);
		rw(1'b0, msa_pkg::REG_CTRL, 32'h0);
		chk("ctrl reg", 32'h2, reg_rdata);
		wait_rdy(1'b0);
		chk("forced private", nd, device_short_address);
		// a request taken while the new address is being drawn is refused
		rw(1'b1, msa_pkg::REG_CTRL, 32'h4);
		tx(2'h2, 16'h0, 1'b1, 1'b0);
		wait_rdy(1'b1);
		test_done();
	end
endmodule : test_mac_short_address_and_rx_accept
